// ---- rtl/lbc_ctrl.sv ----
// How it works
// - Raise bus request; grant input hands over
// - Mastered read data masked to configured bus width
// - Local irq input raises PCI interrupt
// - Irq output low while enabled condition present
// - Disable then enable re-edges irq output
// - Error output low on abort status bits
// - Disable then enable re-edges error output
// - Board reset driven low during chip reset
// - Host strap makes board reset input to PCI
// - Master drives write high, read low
// - Ready input ends mastered beat after waits
// - Device drives ready low answering local master
// - PME request honoured only in D3cold
// - User input pin readable by software
// - Lock input marks atomic direct master access
// - User output pin follows software bit
// - Lock output marks atomic direct slave access
// - Wait input stalls direct master transfer
// - Wait output asserted during generated wait states
// - Byte enables map one lane each
// - Burst increments word address each beat
//
// Our own choices: the APB register port and the register addresses.
module lbc_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Arbitration
  output logic local_bus_request,
  input wire logic local_bus_grant,
  // Address, byte lanes, data
  output logic [29:0] local_word_address,
  output logic local_word_address_oe,
  output logic [3:0] byte_lane_enable_n,
  output logic [31:0] local_data_bus_out,
  output logic local_data_bus_oe,
  input wire logic [31:0] local_data_bus_in,
  // Direction, ready, wait
  input wire logic write_not_read_in,
  output logic write_not_read_out,
  output logic write_not_read_oe,
  input wire logic ready_in_n,
  output logic ready_out_n,
  output logic ready_oe,
  input wire logic wait_in_n,
  output logic wait_out_n,
  output logic wait_oe,
  // Interrupts
  input wire logic local_irq_in_n,
  output logic local_irq_out_n,
  output logic local_irq_out_oe,
  output logic system_error_irq_n,
  output logic system_error_irq_oe,
  // Reset, strap, power
  input wire logic host_mode_strap_n,
  input wire logic board_reset_in_n,
  output logic board_reset_out_n,
  output logic board_reset_oe,
  input wire logic pm_event_request_n,
  // Multiplexed user or lock pins
  input wire logic user_input,
  output logic user_output,
  // Core: device as local master
  input wire logic mst_start,
  input wire logic mst_write,
  input wire logic [29:0] mst_addr,
  input wire logic [31:0] mst_wdata,
  input wire logic [3:0] mst_be_n,
  input wire logic [7:0] mst_beats,
  output logic mst_beat_done,
  output logic [31:0] mst_rdata,
  output logic mst_busy,
  // Core: local master accessing device
  input wire logic slv_select,
  input wire logic [31:0] slv_rdata,
  output logic slv_wr_pulse,
  output logic [31:0] slv_wdata,
  // Core: PCI side events
  input wire logic irq_condition,
  input wire logic target_abort_set,
  input wire logic master_abort_set,
  input wire logic ds_atomic,
  input wire logic power_d3cold,
  output logic pci_irq_request,
  output logic pci_reset_request,
  output logic pme_request,
  output logic dm_lock,
  output logic dm_stall
);
  ////////////////////////////////////////////////////////////////////////
  // Registers and APB
  logic [lbc_pkg::CTRL_W-1:0] ctrl_reg;
  logic [31:0] pcist_reg;
  logic user_out_reg;
  logic user_in_reg;
  logic host_reg;
  logic irq_out_reg;
  logic serr_reg;
  logic lock_out_reg;
  logic brst_reg;

  wire wr_en = psel & penable & pwrite;
  wire hit_ctrl = paddr == lbc_pkg::OFF_CTRL;
  wire hit_stat = paddr == lbc_pkg::OFF_STAT;
  wire hit_pcist = paddr == lbc_pkg::OFF_PCIST;
  wire hit_user = paddr == lbc_pkg::OFF_USER;
  wire hit_any = hit_ctrl | hit_stat | hit_pcist | hit_user;
  wire lock_mode = ctrl_reg[lbc_pkg::CTRL_LOCK_MODE];
  wire [lbc_pkg::WS_W-1:0] ws_cfg = ctrl_reg[lbc_pkg::CTRL_WS_LO +: lbc_pkg::WS_W];
  wire [1:0] bw_cfg = ctrl_reg[lbc_pkg::CTRL_BW_LO +: 2];

  lbc_pkg::lbc_mst_t m_state;
  lbc_pkg::lbc_slv_t s_state;

  wire [31:0] stat_word = {26'h000_0000, host_reg, ~(lock_mode ? user_in_reg : 1'b1),
    m_state != lbc_pkg::M_IDLE, local_bus_grant, irq_out_reg, user_in_reg};

  // Abort bits: hardware set beats software clear
  wire [31:0] pcist_set = (32'h0000_0001 << lbc_pkg::PCIST_TABORT) & {32{target_abort_set}}
    | (32'h0000_0001 << lbc_pkg::PCIST_MABORT) & {32{master_abort_set}};
  wire [31:0] pcist_clr = (wr_en & hit_pcist) ? pwdata : 32'h0000_0000;
  wire [31:0] pcist_next = (pcist_reg & ~pcist_clr) | pcist_set;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata = hit_ctrl ? {22'h00_0000, ctrl_reg} :
                  hit_stat ? stat_word :
                  hit_pcist ? pcist_reg :
                  hit_user ? {31'h0000_0000, user_out_reg} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= lbc_pkg::CTRL_RST;
      user_out_reg <= 1'b0;
      pcist_reg <= 32'h0000_0000;
    end else begin
      if (wr_en & hit_ctrl) begin
        ctrl_reg <= pwdata[lbc_pkg::CTRL_W-1:0];
      end
      if (wr_en & hit_user) begin
        user_out_reg <= pwdata[0];
      end
      pcist_reg <= pcist_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt, error, reset, power and pin-mode levels
  wire irq_out_next = ctrl_reg[lbc_pkg::CTRL_LIRQ_OUT_EN] & irq_condition;
  wire serr_next = ctrl_reg[lbc_pkg::CTRL_SERR_EN]
    & (pcist_reg[lbc_pkg::PCIST_TABORT] | pcist_reg[lbc_pkg::PCIST_MABORT]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out_reg <= 1'b0;
      serr_reg <= 1'b0;
      user_in_reg <= 1'b0;
      lock_out_reg <= 1'b0;
      host_reg <= 1'b0;
      brst_reg <= 1'b0;
    end else begin
      irq_out_reg <= irq_out_next;
      serr_reg <= serr_next;
      user_in_reg <= user_input;
      lock_out_reg <= ds_atomic;
      brst_reg <= 1'b1;
      if (!brst_reg) begin
        host_reg <= ~host_mode_strap_n;
      end
    end
  end

  assign local_irq_out_n = ~irq_out_reg;
  assign local_irq_out_oe = irq_out_reg;
  assign system_error_irq_n = ~serr_reg;
  assign system_error_irq_oe = serr_reg;
  assign board_reset_out_n = brst_reg;
  assign board_reset_oe = ~host_reg;
  assign pci_reset_request = host_reg & ~board_reset_in_n;
  assign pci_irq_request = ctrl_reg[lbc_pkg::CTRL_LIRQ_IN_EN] & ~local_irq_in_n;
  assign pme_request = power_d3cold & ~pm_event_request_n;
  assign user_output = lock_mode ? ~lock_out_reg : user_out_reg;
  assign dm_lock = lock_mode & ~user_input;
  assign dm_stall = ~wait_oe & ~wait_in_n;

  ////////////////////////////////////////////////////////////////////////
  // Device as local master
  lbc_pkg::lbc_mst_t m_next;
  logic [lbc_pkg::WS_W-1:0] m_ws_reg;
  logic [lbc_pkg::BEAT_W-1:0] m_beats_reg;
  logic [29:0] m_addr_reg;
  logic m_write_reg;
  logic [31:0] m_wdata_reg;
  logic [3:0] m_be_reg;
  logic [31:0] m_rdata_reg;
  logic m_done_reg;

  wire m_last = m_beats_reg == {lbc_pkg::BEAT_W{1'b0}};
  wire m_ws_zero = ws_cfg == {lbc_pkg::WS_W{1'b0}};
  wire m_beat_end = (m_state == lbc_pkg::M_DATA) & ~ready_in_n;
  wire m_owns = (m_state != lbc_pkg::M_IDLE) & (m_state != lbc_pkg::M_REQ);
  wire [31:0] bw_mask = (bw_cfg == lbc_pkg::BW_8) ? lbc_pkg::MASK_8 :
                        (bw_cfg == lbc_pkg::BW_16) ? lbc_pkg::MASK_16 : lbc_pkg::MASK_32;

  always_comb begin
    case (m_state)
      lbc_pkg::M_IDLE: m_next = mst_start ? lbc_pkg::M_REQ : lbc_pkg::M_IDLE;
      lbc_pkg::M_REQ: m_next = local_bus_grant ? lbc_pkg::M_ADDR : lbc_pkg::M_REQ;
      lbc_pkg::M_ADDR: m_next = m_ws_zero ? lbc_pkg::M_DATA : lbc_pkg::M_WAIT;
      lbc_pkg::M_WAIT: begin
        m_next = (m_ws_reg == {lbc_pkg::WS_W{1'b0}}) ? lbc_pkg::M_DATA : lbc_pkg::M_WAIT;
      end
      lbc_pkg::M_DATA: begin
        if (!m_beat_end) begin
          m_next = lbc_pkg::M_DATA;
        end else if (m_last) begin
          m_next = lbc_pkg::M_IDLE;
        end else begin
          m_next = m_ws_zero ? lbc_pkg::M_DATA : lbc_pkg::M_WAIT;
        end
      end
      default: m_next = lbc_pkg::M_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_state <= lbc_pkg::M_IDLE;
    end else begin
      m_state <= m_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_ws_reg <= {lbc_pkg::WS_W{1'b0}};
      m_beats_reg <= {lbc_pkg::BEAT_W{1'b0}};
      m_addr_reg <= 30'h0000_0000;
      m_write_reg <= 1'b0;
      m_wdata_reg <= 32'h0000_0000;
      m_be_reg <= 4'hF;
      m_rdata_reg <= 32'h0000_0000;
      m_done_reg <= 1'b0;
    end else begin
      m_done_reg <= m_beat_end;
      if (m_state == lbc_pkg::M_IDLE && mst_start) begin
        m_addr_reg <= mst_addr;
        m_write_reg <= mst_write;
        m_wdata_reg <= mst_wdata;
        m_be_reg <= mst_be_n;
        m_beats_reg <= mst_beats;
      end
      if (m_state == lbc_pkg::M_ADDR || m_beat_end) begin
        m_ws_reg <= ws_cfg - 4'h1;
      end else if (m_state == lbc_pkg::M_WAIT) begin
        m_ws_reg <= m_ws_reg - 4'h1;
      end
      if (m_beat_end) begin
        m_rdata_reg <= local_data_bus_in & bw_mask;
        if (!m_last) begin
          m_addr_reg <= m_addr_reg + 30'h0000_0001;
          m_beats_reg <= m_beats_reg - 8'h01;
        end
      end
    end
  end

  assign local_bus_request = m_state != lbc_pkg::M_IDLE;
  assign local_word_address = m_addr_reg;
  assign local_word_address_oe = m_owns;
  assign byte_lane_enable_n = m_be_reg;
  assign mst_rdata = m_rdata_reg;
  assign mst_beat_done = m_done_reg;
  assign mst_busy = local_bus_request;

  ////////////////////////////////////////////////////////////////////////
  // Local master accessing the device
  lbc_pkg::lbc_slv_t s_next;
  logic [lbc_pkg::WS_W-1:0] s_ws_reg;
  logic [31:0] s_wdata_reg;
  logic s_wr_reg;
  logic [31:0] s_rdata_reg;

  always_comb begin
    case (s_state)
      lbc_pkg::S_IDLE: begin
        if (!slv_select) begin
          s_next = lbc_pkg::S_IDLE;
        end else begin
          s_next = m_ws_zero ? lbc_pkg::S_RDY : lbc_pkg::S_WAIT;
        end
      end
      lbc_pkg::S_WAIT: begin
        s_next = (s_ws_reg == {lbc_pkg::WS_W{1'b0}}) ? lbc_pkg::S_RDY : lbc_pkg::S_WAIT;
      end
      lbc_pkg::S_RDY: s_next = lbc_pkg::S_IDLE;
      default: s_next = lbc_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_state <= lbc_pkg::S_IDLE;
      s_ws_reg <= {lbc_pkg::WS_W{1'b0}};
      s_wdata_reg <= 32'h0000_0000;
      s_wr_reg <= 1'b0;
      s_rdata_reg <= 32'h0000_0000;
    end else begin
      s_state <= s_next;
      s_wr_reg <= (s_state == lbc_pkg::S_RDY) & write_not_read_in;
      if (s_state == lbc_pkg::S_IDLE) begin
        s_ws_reg <= ws_cfg - 4'h1;
      end else begin
        s_ws_reg <= s_ws_reg - 4'h1;
      end
      if (s_next == lbc_pkg::S_RDY) begin
        s_rdata_reg <= slv_rdata;
      end
      if (s_state == lbc_pkg::S_RDY && write_not_read_in) begin
        s_wdata_reg <= local_data_bus_in;
      end
    end
  end

  assign slv_wr_pulse = s_wr_reg;
  assign slv_wdata = s_wdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Shared pins
  wire s_rdy = s_state == lbc_pkg::S_RDY;
  wire s_busy = s_state != lbc_pkg::S_IDLE;
  wire m_data_phase = (m_state == lbc_pkg::M_WAIT) | (m_state == lbc_pkg::M_DATA);

  assign write_not_read_out = m_write_reg;
  assign write_not_read_oe = m_owns;
  assign ready_out_n = ~s_rdy;
  assign ready_oe = s_busy;
  assign wait_out_n = ~((m_state == lbc_pkg::M_WAIT) | (s_state == lbc_pkg::S_WAIT));
  assign wait_oe = m_owns | s_busy;
  assign local_data_bus_out = s_busy ? s_rdata_reg : m_wdata_reg;
  assign local_data_bus_oe = (s_rdy & ~write_not_read_in) | (m_data_phase & m_write_reg);
endmodule

// ---- include/lbc_pkg.sv ----
package lbc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_PCIST = 8'h08;
  localparam logic [7:0] OFF_USER = 8'h0C;
  // Control register fields
  localparam int CTRL_LIRQ_OUT_EN = 0;
  localparam int CTRL_LIRQ_IN_EN = 1;
  localparam int CTRL_SERR_EN = 2;
  localparam int CTRL_LOCK_MODE = 3;
  localparam int CTRL_WS_LO = 4;
  localparam int CTRL_BW_LO = 8;
  localparam int CTRL_W = 10;
  localparam logic [9:0] CTRL_RST = 10'h000;
  // Status register fields
  localparam int STAT_USER_IN = 0;
  localparam int STAT_LIRQ_OUT = 1;
  localparam int STAT_GRANT = 2;
  localparam int STAT_MBUSY = 3;
  localparam int STAT_LOCK_IN = 4;
  localparam int STAT_HOST = 5;
  // PCI status bits
  localparam int PCIST_TABORT = 11;
  localparam int PCIST_MABORT = 13;
  // Widths
  localparam int WS_W = 4;
  localparam int BEAT_W = 8;
  // Bus width codes
  localparam logic [1:0] BW_8 = 2'h0;
  localparam logic [1:0] BW_16 = 2'h1;
  localparam logic [1:0] BW_32 = 2'h2;
  localparam logic [31:0] MASK_8 = 32'h0000_00FF;
  localparam logic [31:0] MASK_16 = 32'h0000_FFFF;
  localparam logic [31:0] MASK_32 = 32'hFFFF_FFFF;

  typedef enum logic [4:0] {
    M_IDLE = 5'b00001,
    M_REQ = 5'b00010,
    M_ADDR = 5'b00100,
    M_WAIT = 5'b01000,
    M_DATA = 5'b10000
  } lbc_mst_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_WAIT = 3'b010,
    S_RDY = 3'b100
  } lbc_slv_t;
endpackage

// ---- verif/lbc_ctrl_props.sv ----
module lbc_ctrl_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Watched pins
  input wire logic local_bus_request,
  input wire logic local_bus_grant,
  input wire logic local_word_address_oe,
  input wire logic mst_start,
  input wire logic mst_busy,
  input wire logic mst_beat_done,
  input wire logic ready_in_n,
  input wire logic ready_out_n,
  input wire logic ready_oe,
  input wire logic wait_out_n,
  input wire logic wait_oe,
  input wire logic irq_condition,
  input wire logic local_irq_out_n,
  input wire logic system_error_irq_n,
  input wire logic system_error_irq_oe,
  input wire logic pme_request,
  input wire logic power_d3cold,
  input wire logic pm_event_request_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_req: assert property (mst_start && !mst_busy |=> local_bus_request)
    else $error("bus request missing after start");
  a_own_after_grant: assert property ($rose(local_word_address_oe) |->
    $past(local_bus_grant && local_bus_request)) else $error("bus taken without grant");
  a_own_needs_req: assert property (local_word_address_oe |-> local_bus_request)
    else $error("bus driven without request");
  a_irq_cause: assert property (!local_irq_out_n |-> $past(irq_condition))
    else $error("irq output without condition");
  a_serr_driven: assert property (!system_error_irq_n |-> system_error_irq_oe)
    else $error("error output asserted but not driven");
  a_beat_on_ready: assert property (mst_beat_done |->
    $past(!ready_in_n && local_word_address_oe)) else $error("beat without ready");
  a_ready_pulse: assert property (!ready_out_n |-> ready_oe ##1 ready_out_n)
    else $error("ready output not one driven cycle");
  a_pme_only_d3: assert property (pme_request |-> power_d3cold && !pm_event_request_n)
    else $error("power event outside deep sleep");
  a_wait_driven: assert property (!wait_out_n |-> wait_oe)
    else $error("wait output asserted but not driven");
endmodule

// ---- verif/lbc_far_end.sv ----
module lbc_far_end (
  // Clock
  input wire logic pclk,
  // From device
  input wire logic local_bus_request,
  input wire logic local_word_address_oe,
  input wire logic [29:0] local_word_address,
  input wire logic write_not_read_out,
  input wire logic [31:0] local_data_bus_out,
  input wire logic wait_out_n,
  // Extra ready delay
  input wire logic [1:0] dly,
  // To device
  output logic local_bus_grant,
  output logic ready_in_n,
  output logic [31:0] local_data_bus_in,
  // Last transfer seen
  output logic [31:0] seen_wdata,
  output logic seen_wnr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic gnt_q = 1'b0;
  logic [2:0] cnt = 3'h0;
  logic go;
  logic [31:0] val;
  // Grant drops with the request at once
  assign local_bus_grant = local_bus_request && gnt_q;
  assign go = local_word_address_oe && wait_out_n && (cnt > {1'b0, dly});
  assign ready_in_n = !go;
  assign val = {local_word_address, 2'b11};
  // Bus not valid outside ready shows inverted data
  assign local_data_bus_in = go ? val : ~val;
  always @(posedge pclk) begin
    gnt_q <= local_bus_request;
    if (!local_word_address_oe || go) begin
      cnt <= 3'h0;
    end else if (wait_out_n && cnt < 3'h7) begin
      cnt <= cnt + 3'h1;
    end
    if (go) begin
      seen_wdata <= local_data_bus_out;
      seen_wnr <= write_not_read_out;
    end
  end
endmodule

// ---- verif/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = '0, mst_beats = '0;
  logic [31:0] pwdata = '0, mst_wdata = '0, slv_rdata = '0, prdata, local_data_bus_out;
  logic [31:0] local_data_bus_in, mst_rdata, slv_wdata, seen_wdata, rd, b;
  logic [29:0] local_word_address, mst_addr = '0;
  logic [3:0] byte_lane_enable_n, mst_be_n = '0;
  logic [1:0] dly = '0;
  logic write_not_read_in = 1, wait_in_n = 1, local_irq_in_n = 1, host_mode_strap_n = 1;
  logic board_reset_in_n = 1, pm_event_request_n = 1, user_input = 0, mst_start = 0;
  logic mst_write = 0, slv_select = 0, irq_condition = 0, target_abort_set = 0, clr = 0;
  logic master_abort_set = 0, ds_atomic = 0, power_d3cold = 0;
  logic local_bus_request, local_bus_grant, local_word_address_oe, local_data_bus_oe;
  logic write_not_read_out, write_not_read_oe, ready_in_n, ready_out_n, ready_oe, wait_out_n;
  logic wait_oe, local_irq_out_n, local_irq_out_oe, system_error_irq_n, system_error_irq_oe;
  logic board_reset_out_n, board_reset_oe, user_output, mst_beat_done, mst_busy, slv_wr_pulse;
  logic pci_irq_request, pci_reset_request, pme_request, dm_lock, dm_stall, seen_wnr;
  int bad_count = 0, checks_done = 0, wcnt = 0;

  always #4 pclk = ~pclk;
  // Counts generated wait cycles
  always @(posedge pclk) wcnt <= clr ? 0 : wcnt + int'(!wait_out_n);

  lbc_ctrl dut (.*);
  lbc_far_end far (.*);

  task give_verdict;
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Waits for 0 pready, 1 beat done, 2 ready out, 3 master idle
  task wt(input int k);
    for (int i = 0; i < 200; i++) begin
      @(posedge pclk);
      if ((k == 0 && pready === 1) || (k == 1 && mst_beat_done === 1) ||
          (k == 2 && ready_out_n === 0) || (k == 3 && mst_busy === 0)) return;
    end
    bad_count++;
    $display("Error at %0t: wait %0d timed out", $time, k);
    give_verdict;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    wt(0);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task start(input logic w, input logic [7:0] n);
    @(posedge pclk);
    clr <= 0; mst_start <= 1; mst_write <= w; mst_addr <= 30'h100; mst_beats <= n;
    @(posedge pclk);
    mst_start <= 0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    cyc(20);
    chk(board_reset_out_n, 0);
    presetn <= 1;
    cyc(2);
    chk(board_reset_out_n, 1);
    apb(0, lbc_pkg::OFF_CTRL, 0); chk(rd, {22'h0, lbc_pkg::CTRL_RST});
    apb(0, 8'h10, 0); chk(err, 1); chk(rd, 0);
    apb(1, lbc_pkg::OFF_USER, 1); cyc(2); chk(user_output, 1);
    user_input <= 1; cyc(3);
    apb(0, lbc_pkg::OFF_STAT, 0); chk(rd[lbc_pkg::STAT_USER_IN], 1);
    irq_condition <= 1; local_irq_in_n <= 0;
    apb(1, lbc_pkg::OFF_CTRL, 3); cyc(2);
    chk(local_irq_out_n, 0);
    chk(local_irq_out_oe, 1);
    chk(pci_irq_request, 1);
    apb(1, lbc_pkg::OFF_CTRL, 0); cyc(2); chk(local_irq_out_n, 1);
    apb(1, lbc_pkg::OFF_CTRL, 1); cyc(2); chk(local_irq_out_n, 0);
    irq_condition <= 0; cyc(3); chk(local_irq_out_n, 1);
    $display("test pins and irq done");
    for (int i = 0; i < 2; i++) begin
      b = (i == 0) ? 32'h0000_0800 : 32'h0000_2000;
      apb(1, lbc_pkg::OFF_CTRL, 4);
      target_abort_set <= (i == 0); master_abort_set <= (i == 1);
      @(posedge pclk);
      target_abort_set <= 0; master_abort_set <= 0;
      cyc(3); chk(system_error_irq_n, 0);
      apb(0, lbc_pkg::OFF_PCIST, 0); chk(rd, b);
      apb(1, lbc_pkg::OFF_CTRL, 0); cyc(2); chk(system_error_irq_n, 1);
      apb(1, lbc_pkg::OFF_CTRL, 4); cyc(2); chk(system_error_irq_n, 0);
      apb(1, lbc_pkg::OFF_PCIST, b); cyc(3); chk(system_error_irq_n, 1);
    end
    pm_event_request_n <= 0; cyc(2); chk(pme_request, 0);
    power_d3cold <= 1; cyc(2); chk(pme_request, 1);
    apb(1, lbc_pkg::OFF_CTRL, 8); ds_atomic <= 1; user_input <= 0; wait_in_n <= 0; cyc(3);
    chk(user_output, 0);
    chk(dm_lock, 1);
    chk(dm_stall, 1);
    ds_atomic <= 0; user_input <= 1; wait_in_n <= 1; cyc(3);
    chk(user_output, 1);
    chk(dm_lock, 0);
    $display("test serr pme lock done");
    apb(1, lbc_pkg::OFF_CTRL, 32'h0000_0120); clr <= 1; mst_be_n <= 4'h3;
    start(0, 8'h01);
    for (int i = 0; i < 2; i++) begin
      wt(1); chk(mst_rdata, {30'h100 + 30'(i), 2'b11} & lbc_pkg::MASK_16);
    end
    wt(3); chk(wcnt, 4);
    chk(byte_lane_enable_n, 4'h3);
    chk(seen_wnr, 0);
    apb(1, lbc_pkg::OFF_CTRL, 32'h0000_0020); clr <= 1;
    start(0, 8'h00);
    wt(1); chk(mst_rdata, 32'h0000_0003);
    wt(3);
    apb(1, lbc_pkg::OFF_CTRL, 32'h0000_0220); clr <= 1; dly <= 2; mst_wdata <= 32'hA5A5_5A5A;
    mst_be_n <= 4'hC;
    start(1, 8'h00);
    wt(1); wt(3);
    chk(seen_wdata, 32'hA5A5_5A5A);
    chk(seen_wnr, 1);
    chk(wcnt, 2);
    chk(byte_lane_enable_n, 4'hC);
    slv_rdata <= 32'h1234_5678; slv_select <= 1; write_not_read_in <= 0;
    wt(2); chk(local_data_bus_out, 32'h1234_5678);
    chk(local_data_bus_oe, 1);
    slv_select <= 0;
    cyc(1);
    write_not_read_in <= 1; slv_select <= 1;
    wt(2); cyc(1);
    chk(slv_wr_pulse, 1);
    chk(slv_wdata, 32'hFFFF_FBFC);
    slv_select <= 0;
    $display("test master and slave done");
    host_mode_strap_n <= 0; presetn <= 0; cyc(2);
    presetn <= 1; cyc(2);
    board_reset_in_n <= 0; cyc(2);
    chk(board_reset_oe, 0);
    chk(pci_reset_request, 1);
    $display("test host strap done");
    give_verdict;
  end
endmodule

bind lbc_ctrl lbc_ctrl_props chk (.*);
